/* File: common/hbdpc_pkg.sv */
// shared constants for the host bus data phase coder
package hbdpc_pkg;
  localparam int DATA_W = 64;
  localparam int GRP_W = 16;
  localparam int GRP_N = 4;
  localparam int GRP_HALF = 8;
  localparam logic [63:0] DATA_RST = 64'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
endpackage

/* File: common/hbdpc_lane_if.sv */
// carries one lane group's previous and next values to the group coder
interface hbdpc_lane_if;
  logic [15:0] prev_bus;
  logic [15:0] next_data;
  logic        invert;
  modport coder (input prev_bus, input next_data, output invert);
  modport user  (output prev_bus, output next_data, input invert);
endinterface

/* File: rtl/hbdpc_grp_coder.sv */
// decides inversion for one 16-bit lane group
module hbdpc_grp_coder
  import hbdpc_pkg::*;
(
  hbdpc_lane_if.coder lane
);
  logic [15:0] diff;
  logic [4:0]  cnt;
  always_comb begin
    diff = lane.prev_bus ^ lane.next_data;
    cnt = 5'h00;
    for (int b = 0; b < GRP_W; b++) begin
      cnt = cnt + {4'h0, diff[b]};
    end
    lane.invert = (cnt > 5'(GRP_HALF)); // see RQ3
  end
endmodule

/* File: rtl/hbdpc_top.sv */
// data phase coder: parity, lane inversion and data-valid for both directions
// Overview of operation
// RQ1: the agent driving the 64 data lines also drives the four parity bits over them.
// RQ2: the transmitter asserts a group's inversion flag when that group is sent inverted.
// RQ3: a group is inverted when more than half its bits would otherwise toggle.
// RQ4: a receiver undoes inversion of each group whose flag is asserted.
// RQ5: the driver asserts data-valid on every transfer word.
// RQ6: the driver may drop data-valid for idle clocks and the receiver ignores those clocks.
// RQ7: flag bit n covers data lines 16n to 16n+15.
module hbdpc_top
  import hbdpc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_tx_valid,
  input  wire logic [63:0] i_tx_data,
  output logic      [63:0] o_bus_data,
  output logic      [3:0]  o_bus_parity,
  output logic      [3:0]  o_bus_invert,
  output logic             o_bus_valid,
  output logic             o_bus_oe,
  input  wire logic [63:0] i_bus_data,
  input  wire logic [3:0]  i_bus_parity,
  input  wire logic [3:0]  i_bus_invert,
  input  wire logic        i_bus_valid,
  output logic             o_rx_valid,
  output logic      [63:0] o_rx_data,
  output logic      [3:0]  o_rx_parity_err
);
  logic [63:0] bus_data_r;
  logic [3:0]  inv_nxt;
  logic [63:0] enc_nxt;
  logic [3:0]  par_nxt;

  genvar g;
  generate
    for (g = 0; g < GRP_N; g++) begin : g_grp
      hbdpc_lane_if lane ();
      assign lane.prev_bus = bus_data_r[g*GRP_W +: GRP_W];   // see RQ7
      assign lane.next_data = i_tx_data[g*GRP_W +: GRP_W];
      hbdpc_grp_coder u_coder (.lane(lane.coder));
      assign inv_nxt[g] = i_tx_valid & lane.invert;
      assign enc_nxt[g*GRP_W +: GRP_W] = inv_nxt[g] ? ~lane.next_data : lane.next_data; // see RQ2
      assign par_nxt[g] = ^enc_nxt[g*GRP_W +: GRP_W]; // see RQ1
    end
  endgenerate

  // transmit side: bus holds last value in idle clocks so toggle count stays honest
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_data_r   <= DATA_RST;
      o_bus_invert <= FLAG_RST;
      o_bus_parity <= FLAG_RST;
      o_bus_valid  <= 1'b0;
      o_bus_oe     <= 1'b0;
    end else begin
      o_bus_valid <= i_tx_valid; // see RQ5
      o_bus_oe    <= i_tx_valid; // see RQ1
      if (i_tx_valid) begin
        bus_data_r   <= enc_nxt;
        o_bus_invert <= inv_nxt; // see RQ2
        o_bus_parity <= par_nxt; // see RQ1
      end
    end
  end
  assign o_bus_data = bus_data_r;

  // receive side: same clock, pins sampled twice
  logic [63:0] rd_s1;
  logic [63:0] rd_s2;
  logic [3:0]  rp_s1;
  logic [3:0]  rp_s2;
  logic [3:0]  ri_s1;
  logic [3:0]  ri_s2;
  logic        rv_s1;
  logic        rv_s2;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_s1 <= DATA_RST;
      rd_s2 <= DATA_RST;
      rp_s1 <= FLAG_RST;
      rp_s2 <= FLAG_RST;
      ri_s1 <= FLAG_RST;
      ri_s2 <= FLAG_RST;
      rv_s1 <= 1'b0;
      rv_s2 <= 1'b0;
    end else begin
      rd_s1 <= i_bus_data;
      rd_s2 <= rd_s1;
      rp_s1 <= i_bus_parity;
      rp_s2 <= rp_s1;
      ri_s1 <= i_bus_invert;
      ri_s2 <= ri_s1;
      rv_s1 <= i_bus_valid;
      rv_s2 <= rv_s1;
    end
  end

  logic [63:0] dec_nxt;
  logic [3:0]  perr_nxt;
  always_comb begin
    for (int n = 0; n < GRP_N; n++) begin
      dec_nxt[n*GRP_W +: GRP_W] = ri_s2[n] ? ~rd_s2[n*GRP_W +: GRP_W] : rd_s2[n*GRP_W +: GRP_W]; // see RQ4
      perr_nxt[n] = (^rd_s2[n*GRP_W +: GRP_W]) ^ rp_s2[n];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_valid      <= 1'b0;
      o_rx_data       <= DATA_RST;
      o_rx_parity_err <= FLAG_RST;
    end else begin
      o_rx_valid <= rv_s2;
      if (rv_s2) begin // see RQ6
        o_rx_data       <= dec_nxt;
        o_rx_parity_err <= perr_nxt;
      end
    end
  end

  // transmit side: valid, enable and idle behaviour
  a_valid_follows: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ5
    i_tx_valid |=> o_bus_valid && o_bus_oe)
    else $error("valid not driven");

  a_idle_no_valid: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ6
    !i_tx_valid |=> !o_bus_valid && $stable(o_bus_data))
    else $error("idle clock not clean");

  a_oe_tracks_valid: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ1
    o_bus_oe == o_bus_valid)
    else $error("drive enable differs from valid");

  a_idle_flags_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ2
    !i_tx_valid |=> $stable(o_bus_invert) && $stable(o_bus_parity))
    else $error("flags changed in idle clock");

  a_parity_match: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ1
    o_bus_valid |-> o_bus_parity == {^o_bus_data[63:48], ^o_bus_data[47:32],
                                     ^o_bus_data[31:16], ^o_bus_data[15:0]})
    else $error("parity wrong");

  // each group must give back the true word once its flag is applied
  a_grp0_recover: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ2
    i_tx_valid |=> (o_bus_data[15:0] ^ {16{o_bus_invert[0]}}) == $past(i_tx_data[15:0]))
    else $error("group 0 not recoverable");

  a_grp1_recover: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ7
    i_tx_valid |=> (o_bus_data[31:16] ^ {16{o_bus_invert[1]}}) == $past(i_tx_data[31:16]))
    else $error("group 1 not recoverable");

  a_grp2_recover: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ7
    i_tx_valid |=> (o_bus_data[47:32] ^ {16{o_bus_invert[2]}}) == $past(i_tx_data[47:32]))
    else $error("group 2 not recoverable");

  a_grp3_recover: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ7
    i_tx_valid |=> (o_bus_data[63:48] ^ {16{o_bus_invert[3]}}) == $past(i_tx_data[63:48]))
    else $error("group 3 not recoverable");

  // flag set exactly when the raw word would toggle more than half the group
  a_grp0_decide: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    i_tx_valid |=> o_bus_invert[0] == ($countones($past(i_tx_data[15:0]) ^ $past(o_bus_data[15:0])) > GRP_HALF))
    else $error("group 0 inversion decision wrong");

  a_grp1_decide: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    i_tx_valid |=> o_bus_invert[1] == ($countones($past(i_tx_data[31:16]) ^ $past(o_bus_data[31:16])) > GRP_HALF))
    else $error("group 1 inversion decision wrong");

  a_grp2_decide: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    i_tx_valid |=> o_bus_invert[2] == ($countones($past(i_tx_data[47:32]) ^ $past(o_bus_data[47:32])) > GRP_HALF))
    else $error("group 2 inversion decision wrong");

  a_grp3_decide: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    i_tx_valid |=> o_bus_invert[3] == ($countones($past(i_tx_data[63:48]) ^ $past(o_bus_data[63:48])) > GRP_HALF))
    else $error("group 3 inversion decision wrong");

  a_toggle_limit: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    o_bus_valid && $past(o_bus_valid) && !$past(i_rst) |->
      $countones(o_bus_data[15:0] ^ $past(o_bus_data[15:0])) <= 8)
    else $error("too many toggles");

  a_toggle_grp1: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    o_bus_valid && $past(o_bus_valid) && !$past(i_rst) |->
      $countones(o_bus_data[31:16] ^ $past(o_bus_data[31:16])) <= 8)
    else $error("too many toggles in group 1");

  a_toggle_grp2: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    o_bus_valid && $past(o_bus_valid) && !$past(i_rst) |->
      $countones(o_bus_data[47:32] ^ $past(o_bus_data[47:32])) <= 8)
    else $error("too many toggles in group 2");

  a_toggle_grp3: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ3
    o_bus_valid && $past(o_bus_valid) && !$past(i_rst) |->
      $countones(o_bus_data[63:48] ^ $past(o_bus_data[63:48])) <= 8)
    else $error("too many toggles in group 3");

  // receive side: latency, decode and idle clocks
  a_rx_latency: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ5
    i_bus_valid |-> ##3 o_rx_valid)
    else $error("rx word not delivered");

  a_rx_decode: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ4
    rv_s2 |=> o_rx_valid && o_rx_data[31:16] == ($past(rd_s2[31:16]) ^ {16{$past(ri_s2[1])}}))
    else $error("rx decode wrong");

  a_rx_decode_g0: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ7
    rv_s2 |=> o_rx_data[15:0] == ($past(rd_s2[15:0]) ^ {16{$past(ri_s2[0])}}))
    else $error("rx group 0 decode wrong");

  a_rx_decode_g2: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ7
    rv_s2 |=> o_rx_data[47:32] == ($past(rd_s2[47:32]) ^ {16{$past(ri_s2[2])}}))
    else $error("rx group 2 decode wrong");

  a_rx_decode_g3: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ7
    rv_s2 |=> o_rx_data[63:48] == ($past(rd_s2[63:48]) ^ {16{$past(ri_s2[3])}}))
    else $error("rx group 3 decode wrong");

  a_rx_parity_flag: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ1
    rv_s2 |=> o_rx_parity_err[0] == ($past(^rd_s2[15:0]) ^ $past(rp_s2[0])))
    else $error("rx parity flag wrong");

  a_rx_idle_hold: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ6
    !rv_s2 |=> !o_rx_valid && $stable(o_rx_data))
    else $error("rx idle not ignored");

  a_rx_idle_err: assert property (@(posedge i_clk) disable iff (i_rst) // see RQ6
    !rv_s2 |=> $stable(o_rx_parity_err))
    else $error("rx parity flag changed in idle clock");
endmodule

/* File: sim/hbdpc_far_agent.sv */
// far-side agent model: echoes each driven word back one clock later
module hbdpc_far_agent (
  input  wire logic        i_clk,
  input  wire logic [63:0] i_data,
  input  wire logic [3:0]  i_par,
  input  wire logic [3:0]  i_inv,
  input  wire logic        i_valid,
  output logic      [63:0] o_data,
  output logic      [3:0]  o_par,
  output logic      [3:0]  o_inv,
  output logic             o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_data, o_par, o_inv, o_valid} = '0;
  always @(posedge i_clk) begin
    o_valid <= i_valid;
    // idle clocks alternate between the complement of the last word and the last word itself
    {o_data, o_par, o_inv} <= i_valid ? {i_data, i_par, i_inv} : ~{o_data, o_par, o_inv};
  end
endmodule

/* File: sim/tb_hbdpc_top.sv */
// self-checking bench for the data phase coder
module tb_hbdpc_top
  import hbdpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, tx_v = 0, bv, oe, rv, fv;
  logic [63:0] tx_d = '0, prev = '0, bd, rd, fd;
  logic [3:0]  bp, bi, rpe, fp, fi;
  logic [63:0] exp_q[$];
  int          n_mismatch = 0, check_count = 0;
  hbdpc_top dut (.i_clk(clk), .i_rst(rst), .i_tx_valid(tx_v), .i_tx_data(tx_d), .o_bus_data(bd),
    .o_bus_parity(bp), .o_bus_invert(bi), .o_bus_valid(bv), .o_bus_oe(oe), .i_bus_data(fd),
    .i_bus_parity(fp), .i_bus_invert(fi), .i_bus_valid(fv), .o_rx_valid(rv), .o_rx_data(rd),
    .o_rx_parity_err(rpe));
  hbdpc_far_agent far (.i_clk(clk), .i_data(bd), .i_par(bp), .i_inv(bi), .i_valid(bv),
    .o_data(fd), .o_par(fp), .o_inv(fi), .o_valid(fv));
  initial forever #4 clk = ~clk;
  task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one word per call; leaves the strobe up so calls run back to back
  task automatic send(input logic [63:0] w);
    logic [63:0] e;
    logic [3:0]  f, p;
    for (int g = 0; g < GRP_N; g++) begin
      f[g] = $countones(prev[g*GRP_W +: GRP_W] ^ w[g*GRP_W +: GRP_W]) > GRP_HALF;
      e[g*GRP_W +: GRP_W] = f[g] ? ~w[g*GRP_W +: GRP_W] : w[g*GRP_W +: GRP_W];
      p[g] = ^e[g*GRP_W +: GRP_W];
    end
    tx_v = 1;
    tx_d = w;
    exp_q.push_back(w);
    @(posedge clk) #1;
    prev = e;
    cmp({bv, oe, 2'h0, bi, bp, bd}, {2'b11, 2'h0, f, p, e});
  endtask
  task automatic idle(input int n);
    tx_v = 0;
    repeat (n) @(posedge clk) #1;
    cmp({bv, oe}, 2'b00);
  endtask
  // received words must match the sent ones, in order, with no parity errors
  always @(negedge clk) if (rv === 1'b1 && !rst) begin
    cmp(rd, exp_q.pop_front());
    cmp(rpe, 4'h0);
  end
  task automatic s_threshold();
    send(64'h0000_01ff_00ff_ffff);
    send(64'h0000_01ff_00ff_ffff);
    idle(8);
    cmp(exp_q.size(), 0);
  endtask
  task automatic s_burst_gap();
    send(64'hffff_ffff_ffff_ffff);
    send(64'h0000_0000_0000_0000);
    send(64'haaaa_aaaa_aaaa_aaaa);
    send(64'h5555_5555_5555_5555);
    idle(2);
    send(64'h0123_4567_89ab_cdef);
    idle(8);
    cmp(exp_q.size(), 0);
  endtask
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    s_threshold();
    s_burst_gap();
    summarize();
  end
endmodule
